// ---- inc/servo_status_pkg.sv ----
// constants and types for the servo drive status bank
// Contract
// - state bits 0-3: commutation done, zero speed, in speed window, up to speed
// - state bits 4-5: at positive and at negative current limit
// - state bits 6-7: power bus charged, drive enabled
// - state bits 8-9: drive ready, release holding brake
// - state bits 10-11: any fault present, any warning present
// - state bit 12 shunt mismatch; bit 13 ready and bus charged
// - state bit 24 mirrors hardware enable; bit 25 auxiliary feedback loss
// - unassigned state bits are reserved and read as zero
// - fault word has one bit per active fault, zero when none
// - fault bits 0-7 memory through secondary feedback fault
// - fault bits 8-15 primary feedback through overspeed
// - fault bits 16-19 assigned; bit 20 reserved
// - fault bits 21-25 relay through AC input overvoltage
// - fault bits 26-29 assigned; bits 30-31 reserved
// - warning bits 0-4 assigned, higher bits reserved, zero when none
// - analog sample signed, clamped to -8192..8191, 8192 counts is 10 V
// - digital input n at bit n-1 for eight inputs, upper bits zero
// - input not assigned to the application reads as zero
package servo_status_pkg;
    localparam logic [11:0] STATE_OFFSET   = 12'h000;
    localparam logic [11:0] FAULT_OFFSET   = 12'h004;
    localparam logic [11:0] WARN_OFFSET    = 12'h008;
    localparam logic [11:0] ANALOG_OFFSET  = 12'h00c;
    localparam logic [11:0] DIGIN_OFFSET   = 12'h010;
    localparam logic [11:0] IRQ_STAT_OFFSET = 12'h014;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h018;
    localparam logic [11:0] APP_MASK_OFFSET = 12'h01c;

    localparam logic [31:0] FAULT_VALID_MASK = 32'h3fef_ffff;
    localparam logic [31:0] WARN_VALID_MASK  = 32'h0000_001f;
    localparam logic [31:0] STATE_VALID_MASK = 32'h0300_3fff;
    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
    localparam logic [7:0]  APP_MASK_RESET   = 8'hff;
    localparam logic [15:0] ANALOG_MAX       = 16'sh1fff;
    localparam logic [15:0] ANALOG_MIN       = 16'she000;
    localparam int          IRQ_BITS         = 3;

    // raw drive conditions feeding the state word
    typedef struct packed {
        logic auxFeedbackLoss;
        logic hwEnable;
        logic shunt220On440;
        logic brakeRelease;
        logic ready;
        logic enabled;
        logic busCharged;
        logic negCurrentLimit;
        logic posCurrentLimit;
        logic upToSpeed;
        logic inSpeedWindow;
        logic zeroSpeed;
        logic commutationDone;
    } drive_cond_t;

    // apb request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// ---- design/servo_drive_status_bank.sv ----
// drive status bank behind an apb slave; status words read-only, interrupt and mask registers writable
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module servo_drive_status_bank (
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire servo_status_pkg::apb_req_t   apbReq,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire servo_status_pkg::drive_cond_t driveCond,
    input  wire logic [31:0]                  faultIn,
    input  wire logic [31:0]                  warnIn,
    input  wire logic signed [15:0]           analogIn,
    input  wire logic [7:0]                   digitalIn,
    output logic                              irq
);
    logic [31:0] stateReg, faultReg, warnReg, analogReg, digInReg;
    logic [31:0] stateNext;
    logic [2:0]  irqStatReg, irqMaskReg;
    logic [7:0]  appMaskReg;
    logic [15:0] analogClamp;
    logic        accessWrite, accessRead;
    logic [2:0]  irqEvent;
    logic        anyFault, anyWarn;

    assign accessWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign accessRead  = apbReq.psel && apbReq.penable && !apbReq.pwrite;
    assign anyFault = |(faultIn & servo_status_pkg::FAULT_VALID_MASK);
    assign anyWarn  = |(warnIn & servo_status_pkg::WARN_VALID_MASK);

    // state word assembly; unassigned bits held at zero
    always_comb begin
        stateNext = servo_status_pkg::ZERO_WORD;
        stateNext[0]  = driveCond.commutationDone;
        stateNext[1]  = driveCond.zeroSpeed;
        stateNext[2]  = driveCond.inSpeedWindow;
        stateNext[3]  = driveCond.upToSpeed;
        stateNext[4]  = driveCond.posCurrentLimit;
        stateNext[5]  = driveCond.negCurrentLimit;
        stateNext[6]  = driveCond.busCharged;
        stateNext[7]  = driveCond.enabled;
        stateNext[8]  = driveCond.ready;
        stateNext[9]  = driveCond.brakeRelease;
        stateNext[10] = anyFault;
        stateNext[11] = anyWarn;
        stateNext[12] = driveCond.shunt220On440;
        stateNext[13] = driveCond.ready && driveCond.busCharged;
        stateNext[24] = driveCond.hwEnable;
        stateNext[25] = driveCond.auxFeedbackLoss;
    end

    // saturate the converter sample into the 14-bit range
    always_comb begin
        if ($signed(analogIn) > $signed(servo_status_pkg::ANALOG_MAX)) begin
            analogClamp = servo_status_pkg::ANALOG_MAX;
        end else if ($signed(analogIn) < $signed(servo_status_pkg::ANALOG_MIN)) begin
            analogClamp = servo_status_pkg::ANALOG_MIN;
        end else begin
            analogClamp = analogIn;
        end
    end

    // status words refresh every cycle; bus writes never reach them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stateReg  <= 32'h0000_0000;
            faultReg  <= 32'h0000_0000;
            warnReg   <= 32'h0000_0000;
            analogReg <= 32'h0000_0000;
            digInReg  <= 32'h0000_0000;
        end else begin
            stateReg  <= stateNext;
            faultReg  <= faultIn & servo_status_pkg::FAULT_VALID_MASK;
            warnReg   <= warnIn & servo_status_pkg::WARN_VALID_MASK;
            analogReg <= {{16{analogClamp[15]}}, analogClamp};
            digInReg  <= {24'h00_0000, digitalIn & appMaskReg};
        end
    end

    // rising edges of fault, warning, up-to-speed raise interrupt events
    assign irqEvent = {stateNext[3] & ~stateReg[3], stateNext[11] & ~stateReg[11],
                       stateNext[10] & ~stateReg[10]};

    // sticky status; a new event beats a simultaneous write-one clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStatReg <= 3'h0;
        end else if (accessWrite && apbReq.paddr == servo_status_pkg::IRQ_STAT_OFFSET) begin
            irqStatReg <= (irqStatReg & ~apbReq.pwdata[2:0]) | irqEvent;
        end else begin
            irqStatReg <= irqStatReg | irqEvent;
        end
    end

    // software configuration: interrupt mask and application input mask
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqMaskReg <= 3'h0;
            appMaskReg <= servo_status_pkg::APP_MASK_RESET;
        end else if (accessWrite) begin
            if (apbReq.paddr == servo_status_pkg::IRQ_MASK_OFFSET) begin
                irqMaskReg <= apbReq.pwdata[2:0];
            end
            if (apbReq.paddr == servo_status_pkg::APP_MASK_OFFSET) begin
                appMaskReg <= apbReq.pwdata[7:0];
            end
        end
    end

    assign irq    = |(irqStatReg & irqMaskReg);
    assign pready = 1'b1; // zero wait states
    // unmapped addresses answer with an error
    assign pslverr = apbReq.psel && apbReq.penable && (apbReq.paddr > servo_status_pkg::APP_MASK_OFFSET
                     || apbReq.paddr[1:0] != 2'h0);

    // read data registered in the setup cycle so it is stable at access
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
            case (apbReq.paddr)
                servo_status_pkg::STATE_OFFSET:    prdata <= stateReg;
                servo_status_pkg::FAULT_OFFSET:    prdata <= faultReg;
                servo_status_pkg::WARN_OFFSET:     prdata <= warnReg;
                servo_status_pkg::ANALOG_OFFSET:   prdata <= analogReg;
                servo_status_pkg::DIGIN_OFFSET:    prdata <= digInReg;
                servo_status_pkg::IRQ_STAT_OFFSET: prdata <= {29'h0, irqStatReg};
                servo_status_pkg::IRQ_MASK_OFFSET: prdata <= {29'h0, irqMaskReg};
                servo_status_pkg::APP_MASK_OFFSET: prdata <= {24'h0, appMaskReg};
                default:                           prdata <= 32'h0000_0000;
            endcase
        end
    end

    a_ready_and_charged: assert property (@(posedge clock) disable iff (rst)
        ##1 (stateReg[13] == (stateReg[8] && stateReg[6]))) else $error("ready-charged bit wrong");
    a_state_reserved: assert property (@(posedge clock) disable iff (rst)
        (stateReg & ~servo_status_pkg::STATE_VALID_MASK) == 32'h0) else $error("reserved state bit set");
    a_fault_summary: assert property (@(posedge clock) disable iff (rst)
        ##1 (stateReg[10] == (faultReg != 32'h0))) else $error("fault summary mismatch");
    a_fault_reserved: assert property (@(posedge clock) disable iff (rst)
        (faultReg & ~servo_status_pkg::FAULT_VALID_MASK) == 32'h0) else $error("reserved fault bit set");
    a_warn_reserved: assert property (@(posedge clock) disable iff (rst)
        warnReg[31:5] == 27'h0) else $error("reserved warning bit set");
    a_analog_range: assert property (@(posedge clock) disable iff (rst)
        $signed(analogReg) <= 8191 && $signed(analogReg) >= -8192) else $error("analog out of range");
    a_digin_masked: assert property (@(posedge clock) disable iff (rst)
        ((digInReg[7:0] & ~$past(appMaskReg)) == 8'h0) && digInReg[31:8] == 24'h0)
        else $error("unassigned input visible");
    a_enable_mirror: assert property (@(posedge clock) disable iff (rst)
        ##1 (stateReg[24] == $past(driveCond.hwEnable))) else $error("enable mirror wrong");
    a_write_no_effect: assert property (@(posedge clock) disable iff (rst)
        accessWrite |=> faultReg == $past(faultIn & servo_status_pkg::FAULT_VALID_MASK))
        else $error("write disturbed fault word");
    a_irq_sticky: assert property (@(posedge clock) disable iff (rst)
        irqEvent[0] |=> irqStatReg[0]) else $error("fault event not latched");

    c_fault_irq: cover property (@(posedge clock) disable iff (rst) irqEvent[0] ##1 irq);
    c_read_state: cover property (@(posedge clock) disable iff (rst)
        accessRead && apbReq.paddr == servo_status_pkg::STATE_OFFSET);
    c_analog_clamp: cover property (@(posedge clock) disable iff (rst)
        $signed(analogIn) > $signed(servo_status_pkg::ANALOG_MAX));
endmodule
`default_nettype wire

// ---- dv/status_reader.sv ----
// apb master model standing in for the controller that reads drive status
`timescale 1ns/1ps
`default_nettype none
module status_reader (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      go,
    input  wire logic                      wr,
    input  wire logic [11:0]               addr,
    input  wire logic [31:0]               wdata,
    input  wire logic [31:0]               prdata,
    input  wire logic                      pready,
    input  wire logic                      pslverr,
    output var servo_status_pkg::apb_req_t apbReq,
    output logic                           done,
    output logic [31:0]                    rdata,
    output logic                           err
);
    // setup, then access held until pready is seen high; no wait count assumed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            apbReq <= '0;
            done <= 1'b0;
            rdata <= 32'h0000_0000;
            err <= 1'b0;
        end else begin
            done <= 1'b0;
            if (apbReq.psel && apbReq.penable && pready) begin
                rdata <= prdata;
                err <= pslverr;
                done <= 1'b1;
                apbReq.psel <= 1'b0;
                apbReq.penable <= 1'b0;
            end else if (apbReq.psel) begin
                apbReq.penable <= 1'b1;
            end else if (go) begin
                apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the drive status bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock = 1'b0, rst = 1'b0, go = 1'b0, wr = 1'b0;
    logic        pready, pslverr, irq, done, err;
    logic [11:0] addr = 12'h000;
    logic [31:0] prdata, rdata, r, faultIn = '0, warnIn = '0, wdata = '0, rngState = 32'h0000_c30b;
    logic [7:0]  digitalIn = '0, appMask;
    logic signed [15:0] analogIn = '0;
    servo_status_pkg::apb_req_t    apbReq;
    servo_status_pkg::drive_cond_t cond = '0;
    int          failCount = 0, checked = 0, v;
    servo_drive_status_bank dut (.clock(clock), .rst(rst), .apbReq(apbReq), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .driveCond(cond), .faultIn(faultIn), .warnIn(warnIn), .analogIn(analogIn),
        .digitalIn(digitalIn), .irq(irq));
    status_reader reader (.clock(clock), .rst(rst), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .apbReq(apbReq), .done(done), .rdata(rdata),
        .err(err));
    initial forever #25 clock = ~clock;
    // xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction
    // reference state word built from the raw conditions
    function automatic logic [31:0] expState();
        logic [31:0] s;
        s = '0;
        s[9:0] = cond[9:0];
        s[10] = |(faultIn & 32'h3fef_ffff);
        s[11] = |(warnIn & 32'h0000_001f);
        s[12] = cond.shunt220On440;
        s[13] = cond.ready & cond.busCharged;
        s[24] = cond.hwEnable;
        s[25] = cond.auxFeedbackLoss;
        return s;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        checked++;
        if (got !== want) begin
            failCount++;
            $display("unexpected at %0t: %s gave %h, expected %h", $time, what, got, want);
        end
    endtask
    // one apb transfer; returns at the edge after pready was taken
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        go <= 1'b0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) begin
            failCount++;
            $display("unexpected at %0t: transfer to %h never completed", $time, a);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] want, input string what);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rdata, want, what);
    endtask
    task automatic summarize();
        $display("checked %0d, mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        failCount++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        #1 rst = 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // random conditions, with reserved-only and empty fault words mixed in
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            cond <= r[12:0];
            digitalIn <= r[20:13];
            analogIn <= (i == 0) ? 16'h2000 : (i == 1) ? 16'hdfff : r[31:16];
            faultIn <= (i % 4 == 0) ? 32'h0 : (i % 4 == 1) ? 32'hc010_0000 : rnd();
            warnIn <= (i % 3 == 0) ? 32'h0 : rnd();
            r = rnd();
            appMask = r[7:0];
            xfer(1'b1, 12'h01c, {24'h0, appMask});
            xfer(1'b1, 12'(4 * (i % 5)), rnd());
            rd(12'h000, expState(), "state word");
            rd(12'h004, faultIn & 32'h3fef_ffff, "fault word");
            rd(12'h008, warnIn & 32'h0000_001f, "warning word");
            v = analogIn;
            v = (v > 8191) ? 8191 : (v < -8192) ? -8192 : v;
            rd(12'h00c, v, "analog sample");
            rd(12'h010, {24'h0, digitalIn & appMask}, "input image");
        end
        $display("test status words done");
        rd(12'h020, 32'h0000_0000, "unmapped read");
        chk({31'h0, err}, 32'h0000_0001, "unmapped error");
        $display("test unmapped done");
        // interrupt: raise, read, mask, clear
        cond <= '0;
        faultIn <= '0;
        warnIn <= '0;
        xfer(1'b1, 12'h014, 32'h0000_0007);
        xfer(1'b1, 12'h018, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0000_0000, "irq idle");
        faultIn <= 32'h0000_0001;
        warnIn <= 32'h0000_0001;
        repeat (4) @(posedge clock);
        chk({31'h0, irq}, 32'h0000_0001, "irq raised");
        rd(12'h014, 32'h0000_0003, "irq status");
        xfer(1'b1, 12'h018, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000, "irq masked");
        xfer(1'b1, 12'h014, 32'h0000_0003);
        xfer(1'b1, 12'h018, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
        $display("test irq done");
        summarize();
    end
endmodule
`default_nettype wire
